// ===== common/cmpd_pkg.sv
// Constants and types shared by the converter control block.
// Assumes a 50 MHz reference clock and a byte-addressed register bus.
package cmpd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int AVG_W = 16;
  localparam int CODE_W = 6;
  localparam int PRE_W = 40;
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_CONFIG = 6'h0f;
  localparam logic [5:0] IDX_PD_TIMER = 6'h10;
  localparam logic [5:0] IDX_DAC1 = 6'h11;
  localparam logic [5:0] IDX_DAC2 = 6'h12;
  localparam logic [5:0] IDX_SERIAL = 6'h13;
  localparam logic [7:0] CONFIG_RST = 8'h19;
  localparam logic [7:0] PD_TIMER_RST = 8'h40;
  localparam logic [7:0] DAC_RST = 8'hc0;
  localparam int MODE_LSB = 0;
  localparam int EN_CH2_BIT = 3;
  localparam int EN_CH1_BIT = 4;
  localparam int RANGE_LSB = 5;
  localparam int THR_FIXED_BIT = 7;
  localparam int DAC_ON_BIT = 7;
  localparam int TRACK_BIT = 6;
  localparam logic [2:0] MD_IDLE = 3'h0;
  localparam logic [2:0] MD_CONT = 3'h1;
  localparam logic [2:0] MD_SINGLE = 3'h2;
  localparam logic [2:0] MD_PDOWN = 3'h3;
  localparam logic [AVG_W-1:0] AVG_HI = 16'hc000;
  localparam logic [AVG_W-1:0] AVG_LO = 16'h4000;
  localparam logic [23:0] STEP_TAB = {6'h08, 6'h04, 6'h02, 6'h01};
  localparam logic [63:0] HOUR4_S = 64'h0000_0000_0000_3840;
  localparam logic [63:0] CLK_HZ = 64'h0000_0000_02fa_f080;
  localparam logic [63:0] HOUR4_CYC = HOUR4_S * CLK_HZ;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_PDOWN = 4'b1000
  } cmpd_state_t;
endpackage : cmpd_pkg

// ===== common/cmpd_tmr_if.sv
// Carrier between the control core and the inactivity timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cmpd_tmr_if;
  logic [5:0] timeout;
  logic kick;
  logic run;
  logic expire;
  modport ctrl (output timeout, output kick, output run, input expire);
  modport timer (input timeout, input kick, input run, output expire);
endinterface : cmpd_tmr_if

// ===== core/cmpd_ctrl.sv
// Mode control, inactivity power-down and offset DAC tracking.
// Assumes converter strobes and averages arrive on ref_clk_i.
//
// What this block does
// - Idle mode keeps everything powered but starts no conversion.
// - Continuous mode converts the enabled channels again and again.
// - Continuous mode with both channels alternates between them.
// - Single mode performs one conversion of the enabled channel.
// - Single mode with both channels converts each channel once.
// - Power-down mode switches the analog side off; the bus keeps working.
// - Timer register at 0x10, eight bits, read and write, resets 0x40.
// - No comparator activity for the set period forces power-down, unless a config register write in the same cycle selects another mode.
// - A config register write selecting a mode other than power-down brings the part back after automatic power-down.
// - Each timeout count adds four hours to the period.
// - Timeout code zero disables the inactivity timer.
// - Per-channel offset DAC registers at 0x11 and 0x12, reset 0xc0.
// - Bit 7 of an offset DAC register turns that DAC on.
// - Bit 6 enables automatic tracking only in adaptive threshold mode.
// - Tracking raises the code when the average passes three quarters.
// - Tracking lowers the code when the average drops below a quarter.
// - The tracking step depends on the selected input range.
// - Fixed threshold mode never adjusts the offset code.
// - Offset code zero means no offset, 0x3f full offset range.
// - Threshold select high means fixed, low means adaptive thresholds.
`timescale 1ns/1ps
module cmpd_ctrl #(
  parameter logic [39:0] STEP_CYC = 40'(cmpd_pkg::HOUR4_CYC),
  // Arbitrary value, stands in for the per-part unique number.
  parameter logic [31:0] SERIAL_ID = 32'h5a5a_0001
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [cmpd_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [cmpd_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [cmpd_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [1:0] cmp_active_i,
  input wire logic conv_done_i,
  input wire logic [cmpd_pkg::AVG_W-1:0] conv_avg_i,
  output logic conv_start_o,
  output logic conv_chan_o,
  output logic analog_on_o,
  output logic [1:0] offset_dac_on_o,
  output logic [cmpd_pkg::CODE_W-1:0] offset_code1_o,
  output logic [cmpd_pkg::CODE_W-1:0] offset_code2_o
);
  import cmpd_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] pdt;
    logic [1:0][7:0] dac;
    cmpd_state_t st;
    logic chan;
    logic last;
    logic ack;
    logic autopd;
    logic [DATA_W-1:0] rdata;
  } cmpd_ctrl_st_t;

  cmpd_ctrl_st_t s_r;
  cmpd_ctrl_st_t s_nxt;

  cmpd_tmr_if tmr ();

  cmpd_pdtimer #(
    .STEP_CYC(STEP_CYC)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .tmr(tmr)
  );

  logic [5:0] idx;
  logic req;
  logic wr_en;
  logic [2:0] mode;
  logic en1;
  logic en2;
  logic done_w;
  logic [1:0] trk;
  logic [1:0][7:0] dac_adj;
  logic [CODE_W-1:0] step;
  logic av_up;
  logic av_dn;
  logic [DATA_W-1:0] rd_mux;

  assign idx = avs_address_i[7:2];
  assign req = avs_read_i | avs_write_i;
  assign wr_en = avs_write_i & s_r.ack & avs_byteenable_i[0];
  assign mode = s_r.cfg[MODE_LSB+:3];
  assign en1 = s_r.cfg[EN_CH1_BIT];
  assign en2 = s_r.cfg[EN_CH2_BIT];
  assign done_w = (s_r.st == ST_WAIT) && conv_done_i;
  assign step = STEP_TAB[6*s_r.cfg[RANGE_LSB+:2]+:6];
  assign av_up = conv_avg_i > AVG_HI;
  assign av_dn = conv_avg_i < AVG_LO;

  // Per-channel tracking: saturating step up or down of the six-bit code.
  generate
    for (genvar c = 0; c < 2; c++) begin : g_trk
      logic [CODE_W:0] sum;
      logic [CODE_W-1:0] code;
      assign code = s_r.dac[c][CODE_W-1:0];
      assign sum = {1'b0, code} + {1'b0, step};
      assign trk[c] = s_r.dac[c][TRACK_BIT] && !s_r.cfg[THR_FIXED_BIT];
      always_comb begin
        dac_adj[c] = s_r.dac[c];
        if (av_up) begin
          dac_adj[c][CODE_W-1:0] = sum[CODE_W] ? 6'h3f : sum[CODE_W-1:0];
        end else if (av_dn) begin
          dac_adj[c][CODE_W-1:0] = (code < step) ? 6'h00 : code - step;
        end
      end
    end
  endgenerate

  always_comb begin
    rd_mux = '0;
    unique case (idx)
      IDX_STATUS: begin
        rd_mux[3:0] = {s_r.autopd, s_r.chan, s_r.st == ST_PDOWN, s_r.st[2] | s_r.st[1]};
      end
      IDX_CONFIG: begin
        rd_mux[7:0] = s_r.cfg;
      end
      IDX_PD_TIMER: begin
        rd_mux[7:0] = s_r.pdt;
      end
      IDX_DAC1: begin
        rd_mux[7:0] = s_r.dac[0];
      end
      IDX_DAC2: begin
        rd_mux[7:0] = s_r.dac[1];
      end
      IDX_SERIAL: begin
        rd_mux = SERIAL_ID;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = req & ~s_r.ack;
    if (avs_read_i && !s_r.ack) begin
      s_nxt.rdata = rd_mux;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (mode == MD_PDOWN) begin
          s_nxt.st = ST_PDOWN;
        end else if ((mode == MD_CONT || mode == MD_SINGLE) && (en1 || en2)) begin
          s_nxt.chan = !en1;
          s_nxt.last = !(en1 && en2);
          s_nxt.st = ST_START;
        end else if (mode == MD_SINGLE) begin
          s_nxt.cfg[MODE_LSB+:3] = MD_IDLE;
        end
      end
      ST_START: begin
        s_nxt.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (mode == MD_PDOWN) begin
          s_nxt.st = ST_PDOWN;
        end else if (conv_done_i) begin
          if (trk[s_r.chan] && s_r.dac[s_r.chan][DAC_ON_BIT]) begin
            s_nxt.dac[s_r.chan] = dac_adj[s_r.chan];
          end
          if (mode == MD_CONT && (en1 || en2)) begin
            s_nxt.chan = (en1 && en2) ? !s_r.chan : !en1;
            s_nxt.st = ST_START;
          end else if (mode == MD_SINGLE && !s_r.last && en2) begin
            s_nxt.chan = 1'b1;
            s_nxt.last = 1'b1;
            s_nxt.st = ST_START;
          end else if (mode == MD_SINGLE) begin
            s_nxt.cfg[MODE_LSB+:3] = MD_IDLE;
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.st = ST_IDLE;
          end
        end
      end
      ST_PDOWN: begin
        if (mode != MD_PDOWN) begin
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
    if (tmr.expire) begin
      s_nxt.cfg[MODE_LSB+:3] = MD_PDOWN;
    end
    if (wr_en) begin
      unique case (idx)
        IDX_CONFIG: begin
          s_nxt.cfg = avs_writedata_i[7:0];
          if (avs_writedata_i[MODE_LSB+:3] != MD_PDOWN) begin
            s_nxt.autopd = 1'b0;
          end
        end
        IDX_PD_TIMER: begin
          s_nxt.pdt = avs_writedata_i[7:0];
        end
        IDX_DAC1: begin
          s_nxt.dac[0] = avs_writedata_i[7:0];
        end
        IDX_DAC2: begin
          s_nxt.dac[1] = avs_writedata_i[7:0];
        end
        default: begin
        end
      endcase
    end
    if (tmr.expire) begin
      s_nxt.autopd = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r.cfg <= CONFIG_RST;
      s_r.pdt <= PD_TIMER_RST;
      s_r.dac <= {DAC_RST, DAC_RST};
      s_r.st <= ST_IDLE;
      s_r.chan <= 1'b0;
      s_r.last <= 1'b0;
      s_r.ack <= 1'b0;
      s_r.autopd <= 1'b0;
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tmr.timeout = s_r.pdt[5:0];
  assign tmr.kick = (|cmp_active_i) | (wr_en && idx == IDX_PD_TIMER);
  assign tmr.run = s_r.st != ST_PDOWN;

  assign avs_waitrequest_o = req & ~s_r.ack;
  assign avs_readdata_o = s_r.rdata;
  assign conv_start_o = s_r.st == ST_START;
  assign conv_chan_o = s_r.chan;
  assign analog_on_o = s_r.st != ST_PDOWN;
  assign offset_dac_on_o = {s_r.dac[1][DAC_ON_BIT], s_r.dac[0][DAC_ON_BIT]};
  assign offset_code1_o = s_r.dac[0][CODE_W-1:0];
  assign offset_code2_o = s_r.dac[1][CODE_W-1:0];

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence seq_cont_both_done;
    done_w && mode == MD_CONT && en1 && en2 && !wr_en;
  endsequence

  sequence seq_single_last_done;
    done_w && mode == MD_SINGLE && (s_r.last || !en2) && !wr_en;
  endsequence

  sequence seq_track_up_ch1;
    done_w && !s_r.chan && trk[0] && s_r.dac[0][DAC_ON_BIT] && av_up && !wr_en;
  endsequence

  sequence seq_track_room_ch1;
    seq_track_up_ch1 ##0 offset_code1_o < 6'h38;
  endsequence

  a_idle_no_start: assert property (
    s_r.st == ST_IDLE && mode == MD_IDLE && !wr_en |=> !conv_start_o [*2])
    else $error("conversion started in idle mode");

  a_cont_restart: assert property (
    done_w && mode == MD_CONT && (en1 || en2) && !wr_en |=> conv_start_o)
    else $error("continuous mode did not restart");

  a_cont_alternate: assert property (
    seq_cont_both_done |=> conv_start_o && conv_chan_o != $past(conv_chan_o))
    else $error("continuous mode did not alternate channels");

  a_single_end: assert property (
    seq_single_last_done |=> s_r.st == ST_IDLE && mode == MD_IDLE ##1 !conv_start_o)
    else $error("single conversion did not end in idle");

  a_single_second: assert property (
    done_w && mode == MD_SINGLE && !s_r.last && en2 && !wr_en |=> conv_start_o && conv_chan_o)
    else $error("second single conversion missing");

  a_pdown_quiet: assert property (
    s_r.st == ST_PDOWN |-> !conv_start_o && !analog_on_o)
    else $error("analog side active in power-down");

  a_timer_pdown: assert property (
    tmr.expire && !wr_en |=> mode == MD_PDOWN ##1 s_r.st == ST_PDOWN)
    else $error("inactivity timeout did not power down");

  a_timer_off: assert property (
    s_r.pdt[5:0] == 6'h00 |-> !tmr.expire)
    else $error("timer expired while disabled");

  a_fixed_hold: assert property (
    s_r.cfg[THR_FIXED_BIT] && !wr_en |=> $stable(s_r.dac))
    else $error("offset code moved in fixed threshold mode");

  a_track_up: assert property (
    seq_track_up_ch1 |=> offset_code1_o > $past(offset_code1_o) || offset_code1_o == 6'h3f)
    else $error("offset code did not rise");

  a_bus_answer: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait request held longer than one cycle");

  a_track_step: assert property (
    seq_track_room_ch1 |=>
      offset_code1_o == $past(offset_code1_o) + (6'h01 << $past(s_r.cfg[RANGE_LSB+:2])))
    else $error("offset code step does not match the range");

  a_track_down: assert property (
    done_w && !s_r.chan && trk[0] && s_r.dac[0][DAC_ON_BIT] && av_dn && !wr_en |=>
      offset_code1_o < $past(offset_code1_o) || offset_code1_o == 6'h00)
    else $error("offset code did not fall");

  a_track_off: assert property (
    done_w && !s_r.chan && !s_r.dac[0][TRACK_BIT] && !wr_en |=> $stable(offset_code1_o))
    else $error("offset code moved with tracking off");

  a_wait_to_idle: assert property (
    done_w && mode == MD_IDLE && !wr_en |=> s_r.st == ST_IDLE)
    else $error("idle mode kept converting");

  a_pdown_wake: assert property (
    s_r.st == ST_PDOWN && wr_en && idx == IDX_CONFIG &&
      avs_writedata_i[MODE_LSB+:3] != MD_PDOWN |=> ##1 analog_on_o)
    else $error("config write did not wake the part");

  a_dac_enable: assert property (
    wr_en && idx == IDX_DAC2 |=> offset_dac_on_o[1] == $past(avs_writedata_i[DAC_ON_BIT]))
    else $error("offset DAC enable does not follow its register");

  a_timer_write: assert property (
    wr_en && idx == IDX_PD_TIMER |=> s_r.pdt == $past(avs_writedata_i[7:0]))
    else $error("timer register write lost");
endmodule : cmpd_ctrl

// ===== core/cmpd_pdtimer.sv
// Inactivity timer counting whole steps of the programmed period.
// Assumes kick and run come from logic on the same clock.
`timescale 1ns/1ps
module cmpd_pdtimer #(
  parameter logic [39:0] STEP_CYC = 40'h00_0000_0010
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  cmpd_tmr_if.timer tmr
);
  import cmpd_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [5:0] steps;
    logic expire;
  } cmpd_tmr_st_t;

  cmpd_tmr_st_t s_r;
  cmpd_tmr_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (tmr.kick || !tmr.run || (tmr.timeout == 6'h00)) begin
      s_nxt.pre = '0;
      s_nxt.steps = 6'h00;
    end else if (s_r.pre == STEP_CYC - 40'h00_0000_0001) begin
      s_nxt.pre = '0;
      if (s_r.steps + 6'h01 == tmr.timeout) begin
        s_nxt.expire = 1'b1;
        s_nxt.steps = 6'h00;
      end else begin
        s_nxt.steps = s_r.steps + 6'h01;
      end
    end else begin
      s_nxt.pre = s_r.pre + 40'h00_0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tmr.expire = s_r.expire;
endmodule : cmpd_pdtimer

// ===== testbench/tb_top.sv
// Self-checking bench for the converter control block.
// Assumes a shortened timeout step of 16 cycles; bus waits follow waitrequest.
`timescale 1ns/1ps
module tb_top;
  import cmpd_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] cmp_active_i = 2'h0;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_avg_i = 16'h0;
  logic conv_start_o;
  logic conv_chan_o;
  logic analog_on_o;
  logic [1:0] offset_dac_on_o;
  logic [5:0] offset_code1_o;
  logic [5:0] offset_code2_o;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic hit;
  int n_pd;

  cmpd_ctrl #(.STEP_CYC(40'h00_0000_0010)) DUT (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .cmp_active_i(cmp_active_i),
    .conv_done_i(conv_done_i), .conv_avg_i(conv_avg_i), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .analog_on_o(analog_on_o), .offset_dac_on_o(offset_dac_on_o),
    .offset_code1_o(offset_code1_o), .offset_code2_o(offset_code2_o)
  );

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (n == 20) begin
      n_errors++;
      finish_test();
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rchk

  task automatic wait_start(input int lim);
    int n;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++) begin
      @(negedge ref_clk_i);
      hit = (conv_start_o === 1'b1);
    end
  endtask : wait_start

  task automatic need_start(input logic ch);
    wait_start(20);
    if (!hit) begin
      n_errors++;
      finish_test();
    end
    chk(32'(conv_chan_o), 32'(ch), "channel");
  endtask : need_start

  task automatic done(input logic [15:0] avg);
    @(posedge ref_clk_i);
    conv_done_i <= 1'b1;
    conv_avg_i <= avg;
    @(posedge ref_clk_i);
    conv_done_i <= 1'b0;
  endtask : done

  task automatic step(input logic [15:0] avg, input logic ch, input logic [5:0] c1,
                      input logic [5:0] c2);
    done(avg);
    need_start(ch);
    chk(32'(offset_code1_o), 32'(c1), "code ch1");
    chk(32'(offset_code2_o), 32'(c2), "code ch2");
  endtask : step

  task automatic settle(input logic exp_on);
    repeat (3) @(negedge ref_clk_i);
    chk(32'(analog_on_o), 32'(exp_on), "analog on");
  endtask : settle

  initial begin
    repeat (8) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    need_start(1'b0);
    rchk(8'h40, 32'h40, "timer reset");
    rchk(8'h44, 32'hc0, "dac1 reset");
    rchk(8'h48, 32'hc0, "dac2 reset");
    rchk(8'h80, 32'h0, "unmapped");
    chk(32'(offset_dac_on_o), 32'h3, "dac on");
    bus(1'b1, 8'h48, 32'h40);
    @(negedge ref_clk_i);
    chk(32'(offset_dac_on_o), 32'h1, "dac2 off");
    bus(1'b1, 8'h48, 32'hc0);
    step(16'hd000, 1'b1, 6'h01, 6'h00);
    step(16'hd000, 1'b0, 6'h01, 6'h01);
    step(16'h1000, 1'b1, 6'h00, 6'h01);
    bus(1'b1, 8'h3c, 32'h31);
    step(16'h8000, 1'b0, 6'h00, 6'h01);
    step(16'hd000, 1'b0, 6'h02, 6'h01);
    bus(1'b1, 8'h3c, 32'hb1);
    step(16'hd000, 1'b0, 6'h02, 6'h01);
    bus(1'b1, 8'h3c, 32'h71);
    step(16'hd000, 1'b0, 6'h0a, 6'h01);
    rchk(8'h44, 32'hca, "dac1 code");
    avs_byteenable_i <= 4'he;
    bus(1'b1, 8'h44, 32'h8a);
    avs_byteenable_i <= 4'hf;
    rchk(8'h44, 32'hca, "lane 0 off");
    bus(1'b1, 8'h44, 32'h8a);
    step(16'hd000, 1'b0, 6'h0a, 6'h01);
    bus(1'b1, 8'h3c, 32'h18);
    done(16'h8000);
    wait_start(30);
    chk(32'(hit), 32'h0, "idle start");
    bus(1'b1, 8'h3c, 32'h1a);
    need_start(1'b0);
    done(16'h8000);
    need_start(1'b1);
    done(16'h8000);
    wait_start(30);
    chk(32'(hit), 32'h0, "extra single");
    rchk(8'h3c, 32'h18, "single end");
    bus(1'b1, 8'h3c, 32'h12);
    need_start(1'b0);
    done(16'h8000);
    wait_start(30);
    chk(32'(hit), 32'h0, "extra single");
    rchk(8'h3c, 32'h10, "single end");
    bus(1'b1, 8'h3c, 32'h1b);
    settle(1'b0);
    rchk(8'h40, 32'h40, "bus in pdown");
    bus(1'b1, 8'h3c, 32'h18);
    settle(1'b1);
    repeat (40) @(negedge ref_clk_i);
    settle(1'b1);
    bus(1'b1, 8'h40, 32'h42);
    repeat (20) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    cmp_active_i <= 2'b10;
    @(posedge ref_clk_i);
    cmp_active_i <= 2'b00;
    for (n_pd = 0; n_pd < 100 && analog_on_o !== 1'b0; n_pd++) @(negedge ref_clk_i);
    chk(32'(n_pd >= 30 && n_pd <= 40), 32'h1, "timeout length");
    rchk(8'h3c, 32'h1b, "auto mode");
    rchk(8'h00, 32'ha, "status");
    bus(1'b1, 8'h40, 32'h40);
    bus(1'b1, 8'h3c, 32'h18);
    settle(1'b1);
    rchk(8'h00, 32'h0, "status after wake");
    finish_test();
  end
endmodule : tb_top
